// >>> src/sbp_barricade.sv
// barricade and relocation registers with load and store sequencer
//
// Behaviour
// R01: load basic form copies character at A into barricade bank count
// R02: protected area runs from barricade bank start to memory top
// R03: extended variant takes seventh bit from rightmost bit at A-1
// R04: relocation form loads base bank from B, seventh bit from B-1
// R05: standard mode references add base; interrupt mode ones do not
// R06: relocation form offsets barricade by the base relocation address
// R07: protected stores refused outside window unless in interrupt mode
// R08: barricade position is register value times 4096 locations
// R09: neither instruction alters any word mark in memory
// R10: after either, sequence next, A reg A-2, B reg B or B-2
// R11: fifteen extra index registers sit in 60 chars past barricade
// R12: those 60 locations act as ordinary storage otherwise
// R13: load barricade is privileged while protection is active
// R14: software should issue both instructions only in interrupt mode
// R15: store writes barricade to A, clearing unused high bits
// R16: extended store puts seventh bit in A-1, other five cleared
// R17: relocation store writes base to B, seventh bit to B-1
// R18: refused stores leave memory unchanged and flag a violation
`timescale 1ns/1ps
`default_nettype none
`include "sbp_defines.svh"
module sbp_barricade
  import sbp_pkg::*;
#(
  parameter bit EXTENDED = 1'b0
)(
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    load_barricade_instruction_i,
  input  wire logic                    store_barricade_instruction_i,
  input  wire logic                    reloc_form_i,
  input  wire logic [`SBP_ADDR_W-1:0]  a_addr_i,
  input  wire logic [`SBP_ADDR_W-1:0]  b_addr_i,
  input  wire logic [`SBP_ADDR_W-1:0]  next_instruction_addr_i,
  input  wire logic                    intr_mode_i,
  input  wire logic                    prot_on_i,
  input  wire logic                    cpu_req_i,
  input  wire logic                    cpu_we_i,
  input  wire logic [`SBP_ADDR_W-1:0]  cpu_addr_i,
  input  wire logic [`SBP_CHAR_W-1:0]  cpu_wdata_i,
  input  wire logic [`SBP_CHAR_W-1:0]  mem_rdata_i,
  output logic                         mem_req_o,
  output logic                         mem_we_o,
  output logic                         mem_wm_keep_o,
  output logic      [`SBP_ADDR_W-1:0]  mem_addr_o,
  output logic      [`SBP_CHAR_W-1:0]  mem_wdata_o,
  output logic                         busy_o,
  output logic                         done_o,
  output logic                         privileged_trap_o,
  output logic                         violation_o,
  output logic      [`SBP_REG_W-1:0]   barricade_bank_count_o,
  output logic      [`SBP_REG_W-1:0]   relocation_bank_base_o,
  output logic      [`SBP_ADDR_W-1:0]  index_base_o,
  output logic      [`SBP_ADDR_W-1:0]  sequence_reg_o,
  output logic      [`SBP_ADDR_W-1:0]  a_operand_addr_reg_o,
  output logic      [`SBP_ADDR_W-1:0]  b_operand_addr_reg_o
);
  sbp_state_t state;
  logic [`SBP_REG_W-1:0]  barricade_bank_count;
  logic [`SBP_REG_W-1:0]  relocation_bank_base;
  logic                   reloc_mode;
  logic                   op_reloc;
  logic [`SBP_ADDR_W-1:0] op_a;
  logic [`SBP_ADDR_W-1:0] op_b;
  logic [`SBP_CHAR_W-1:0] next_char;
  logic [`SBP_ADDR_W-1:0] reloc_addr;
  logic [`SBP_ADDR_W-1:0] limit;
  logic                   allowed;
  logic                   cpu_write;
  logic                   start_load;
  logic                   start_store;
  logic                   trap;

  function automatic logic [`SBP_ADDR_W-1:0] sub_addr(
    input logic [`SBP_ADDR_W-1:0] x,
    input logic [`SBP_ADDR_W-1:0] d
  );
    sub_addr = x - d;
  endfunction : sub_addr

  // store form of a register: low six bits, high bits cleared
  function automatic logic [`SBP_CHAR_W-1:0] low_char(
    input logic [`SBP_REG_W-1:0] r
  );
    low_char = r[`SBP_CHAR_W-1:0];
  endfunction : low_char

  function automatic logic [`SBP_CHAR_W-1:0] top_char(
    input logic [`SBP_REG_W-1:0] r
  );
    top_char = {{(`SBP_CHAR_W-1){1'b0}}, r[`SBP_HI_BIT]};
  endfunction : top_char

  assign trap = load_barricade_instruction_i && prot_on_i && !intr_mode_i; // R13
  assign start_load  = (state == SBP_IDLE) && load_barricade_instruction_i
                       && !trap;
  assign start_store = (state == SBP_IDLE) && store_barricade_instruction_i
                       && !load_barricade_instruction_i;
  assign cpu_write = (state == SBP_IDLE) && cpu_req_i && cpu_we_i
                     && !load_barricade_instruction_i
                     && !store_barricade_instruction_i;

  sbp_reloc u_reloc (
    .logical_i   (cpu_addr_i),
    .base_bank_i (relocation_bank_base),
    .intr_mode_i (intr_mode_i),
    .physical_o  (reloc_addr)
  );

  sbp_window u_window (
    .phys_i       (reloc_addr),
    .barr_bank_i  (barricade_bank_count),
    .base_bank_i  (relocation_bank_base),
    .reloc_form_i (reloc_mode),
    .prot_on_i    (prot_on_i),
    .intr_mode_i  (intr_mode_i),
    .allowed_o    (allowed),
    .limit_o      (limit)
  );

  // sequencer: one memory character per state
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= SBP_IDLE;
    end else begin
      unique case (state)
        SBP_IDLE: begin
          if (start_load) begin
            state <= EXTENDED ? SBP_RD_A1 : SBP_RD_A;
          end else if (start_store) begin
            state <= SBP_WR_A;
          end
        end
        SBP_RD_A1: state <= SBP_RD_A;
        SBP_RD_A: begin
          if (op_reloc) begin
            state <= EXTENDED ? SBP_RD_B1 : SBP_RD_B;
          end else begin
            state <= SBP_IDLE;
          end
        end
        SBP_RD_B1: state <= SBP_RD_B;
        SBP_RD_B:  state <= SBP_IDLE;
        SBP_WR_A: state <= EXTENDED ? SBP_WR_A1 :
                           (op_reloc ? SBP_WR_B : SBP_IDLE);
        SBP_WR_A1: state <= op_reloc ? SBP_WR_B : SBP_IDLE;
        SBP_WR_B:  state <= EXTENDED ? SBP_WR_B1 : SBP_IDLE;
        SBP_WR_B1: state <= SBP_IDLE;
        default:   state <= SBP_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_reloc <= 1'b0;
      op_a     <= '0;
      op_b     <= '0;
    end else if (start_load || start_store) begin
      op_reloc <= reloc_form_i;
      op_a     <= a_addr_i;
      op_b     <= b_addr_i;
    end
  end

  // memory answers in the cycle the address is shown
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      barricade_bank_count <= '0;
      relocation_bank_base <= '0;
      reloc_mode           <= 1'b0;
    end else begin
      unique case (state)
        SBP_RD_A1: barricade_bank_count[`SBP_HI_BIT] <=
                   mem_rdata_i[`SBP_LOW_BIT]; // R03
        SBP_RD_A: begin
          barricade_bank_count[`SBP_CHAR_W-1:0] <= mem_rdata_i; // R01
          if (!EXTENDED) begin
            barricade_bank_count[`SBP_HI_BIT] <= 1'b0;
          end
          reloc_mode <= op_reloc; // R06
        end
        SBP_RD_B1: relocation_bank_base[`SBP_HI_BIT] <=
                   mem_rdata_i[`SBP_LOW_BIT]; // R04
        SBP_RD_B: begin
          relocation_bank_base[`SBP_CHAR_W-1:0] <= mem_rdata_i; // R04
          if (!EXTENDED) begin
            relocation_bank_base[`SBP_HI_BIT] <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // memory port
  always_comb begin
    mem_req_o   = 1'b0;
    mem_we_o    = 1'b0;
    mem_addr_o  = '0;
    mem_wdata_o = '0;
    next_char   = '0;
    unique case (state)
      SBP_IDLE: begin
        // refused stores never reach memory
        mem_req_o   = cpu_req_i && !load_barricade_instruction_i
                      && !store_barricade_instruction_i
                      && (!cpu_we_i || allowed); // R18 R07
        mem_we_o    = cpu_write && allowed; // R12
        mem_addr_o  = reloc_addr; // R05
        mem_wdata_o = cpu_wdata_i;
      end
      SBP_RD_A: begin
        mem_req_o  = 1'b1;
        mem_addr_o = op_a;
      end
      SBP_RD_A1: begin
        mem_req_o  = 1'b1;
        mem_addr_o = sub_addr(op_a, `SBP_OFS_ONE);
      end
      SBP_RD_B: begin
        mem_req_o  = 1'b1;
        mem_addr_o = op_b;
      end
      SBP_RD_B1: begin
        mem_req_o  = 1'b1;
        mem_addr_o = sub_addr(op_b, `SBP_OFS_ONE);
      end
      SBP_WR_A: begin
        next_char   = low_char(barricade_bank_count); // R15
        mem_req_o   = 1'b1;
        mem_we_o    = 1'b1;
        mem_addr_o  = op_a;
        mem_wdata_o = next_char;
      end
      SBP_WR_A1: begin
        mem_req_o   = 1'b1;
        mem_we_o    = 1'b1;
        mem_addr_o  = sub_addr(op_a, `SBP_OFS_ONE);
        mem_wdata_o = top_char(barricade_bank_count); // R16
      end
      SBP_WR_B: begin
        mem_req_o   = 1'b1;
        mem_we_o    = 1'b1;
        mem_addr_o  = op_b;
        mem_wdata_o = low_char(relocation_bank_base); // R17
      end
      SBP_WR_B1: begin
        mem_req_o   = 1'b1;
        mem_we_o    = 1'b1;
        mem_addr_o  = sub_addr(op_b, `SBP_OFS_ONE);
        mem_wdata_o = top_char(relocation_bank_base); // R17
      end
    endcase
  end

  // data bits only; the word-mark bit of each location is preserved
  assign mem_wm_keep_o = 1'b1; // R09

  logic last_step;
  always_comb begin
    last_step = 1'b0;
    unique case (state)
      SBP_RD_A:  last_step = !op_reloc;
      SBP_RD_B:  last_step = 1'b1;
      SBP_WR_A:  last_step = !EXTENDED && !op_reloc;
      SBP_WR_A1: last_step = !op_reloc;
      SBP_WR_B:  last_step = !EXTENDED;
      SBP_WR_B1: last_step = 1'b1;
      default:   last_step = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_o               <= 1'b0;
      sequence_reg_o       <= '0;
      a_operand_addr_reg_o <= '0;
      b_operand_addr_reg_o <= '0;
    end else begin
      done_o <= last_step;
      if (last_step) begin
        sequence_reg_o       <= next_instruction_addr_i; // R10
        a_operand_addr_reg_o <= sub_addr(op_a, `SBP_OFS_TWO); // R10
        b_operand_addr_reg_o <= op_reloc ?
                                sub_addr(op_b, `SBP_OFS_TWO) : op_b; // R10
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      violation_o       <= 1'b0;
      privileged_trap_o <= 1'b0;
    end else begin
      violation_o       <= cpu_write && !allowed; // R18
      privileged_trap_o <= trap && (state == SBP_IDLE); // R13
    end
  end

  // index registers are ordinary memory; this only locates them
  assign index_base_o = limit; // R11 R12
  assign busy_o = (state != SBP_IDLE);
  assign barricade_bank_count_o = barricade_bank_count;
  assign relocation_bank_base_o = relocation_bank_base;

  // full-width window top, so a wrapped limit cannot fool the check
  logic [`SBP_ADDR_W:0] win_top;
  assign win_top = {1'b0, barricade_bank_count, {`SBP_BANK_SHIFT{1'b0}}}
                   + (reloc_mode ? {1'b0, relocation_bank_base,
                                    {`SBP_BANK_SHIFT{1'b0}}} : '0);

  a_no_write_trap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state == SBP_IDLE && cpu_write && !allowed) |-> !mem_we_o) // R18
    else $error("refused store reached memory");
  a_violation_flag: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cpu_write && !allowed) |=> violation_o) // R18
    else $error("violation not flagged");
  a_intr_no_reloc: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state == SBP_IDLE && intr_mode_i) |-> reloc_addr == cpu_addr_i) // R05
    else $error("interrupt mode address relocated");
  a_window_block: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (prot_on_i && !intr_mode_i && {1'b0, reloc_addr} >= win_top)
      |-> !allowed) // R07
    else $error("store past barricade allowed");
  a_load_a_reg: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state == SBP_RD_A) |=> barricade_bank_count[`SBP_CHAR_W-1:0]
                            == $past(mem_rdata_i)) // R01
    else $error("barricade not loaded from A");
  a_a_minus_two: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    last_step |=> a_operand_addr_reg_o == $past(op_a) - `SBP_OFS_TWO) // R10
    else $error("A register not A-2");
  a_priv_trap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state == SBP_IDLE && trap) |=> privileged_trap_o && state == SBP_IDLE) // R13
    else $error("privileged load not trapped");
  a_store_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state == SBP_WR_A1 || state == SBP_WR_B1)
      |-> mem_wdata_o[`SBP_CHAR_W-1:1] == '0) // R16
    else $error("upper bits of minus one char not cleared");
  a_wm_kept: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    mem_we_o |-> mem_wm_keep_o) // R09
    else $error("word mark not preserved");
  a_store_done: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    start_store && !reloc_form_i && !EXTENDED |=> ##1 done_o) // R15
    else $error("store not done in time");
  a_store_ext_done: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    start_store && !reloc_form_i && EXTENDED |=> ##2 done_o) // R16
    else $error("extended store not done in time");

  c_load: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    state == SBP_RD_B ##1 done_o);
  c_store: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    state == SBP_WR_B);
  c_violation: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    violation_o);
  c_trap: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    privileged_trap_o);
endmodule : sbp_barricade
`default_nettype wire

// >>> src/sbp_defines.svh
// constants for the storage barricade protection unit
`ifndef SBP_DEFINES_SVH
`define SBP_DEFINES_SVH
`define SBP_ADDR_W      19
`define SBP_REG_W       7
`define SBP_CHAR_W      6
`define SBP_BANK_SHIFT  12
`define SBP_IDX_CHARS   19'h0003C
`define SBP_OFS_TWO     19'h00002
`define SBP_OFS_ONE     19'h00001
`define SBP_HI_BIT      6
`define SBP_LOW_BIT     0
`endif

// >>> src/sbp_pkg.sv
// types for the storage barricade protection unit
package sbp_pkg;
  typedef enum logic [3:0] {
    SBP_IDLE, SBP_RD_A, SBP_RD_A1, SBP_RD_B, SBP_RD_B1,
    SBP_WR_A, SBP_WR_A1, SBP_WR_B, SBP_WR_B1
  } sbp_state_t;
endpackage : sbp_pkg

// >>> src/sbp_reloc.sv
// address relocation for standard mode references
`timescale 1ns/1ps
`default_nettype none
`include "sbp_defines.svh"
module sbp_reloc
  import sbp_pkg::*;
(
  input  wire logic [`SBP_ADDR_W-1:0] logical_i,
  input  wire logic [`SBP_REG_W-1:0]  base_bank_i,
  input  wire logic                   intr_mode_i,
  output logic      [`SBP_ADDR_W-1:0] physical_o
);
  logic [`SBP_ADDR_W-1:0] offset;
  assign offset = {base_bank_i, {`SBP_BANK_SHIFT{1'b0}}};
  // interrupt mode refers to absolute memory
  assign physical_o = intr_mode_i ? logical_i : logical_i + offset; // R05
endmodule : sbp_reloc
`default_nettype wire

// >>> src/sbp_window.sv
// store permission check against base and barricade
`timescale 1ns/1ps
`default_nettype none
`include "sbp_defines.svh"
module sbp_window
  import sbp_pkg::*;
(
  input  wire logic [`SBP_ADDR_W-1:0] phys_i,
  input  wire logic [`SBP_REG_W-1:0]  barr_bank_i,
  input  wire logic [`SBP_REG_W-1:0]  base_bank_i,
  input  wire logic                   reloc_form_i,
  input  wire logic                   prot_on_i,
  input  wire logic                   intr_mode_i,
  output logic                        allowed_o,
  output logic      [`SBP_ADDR_W-1:0] limit_o
);
  logic [`SBP_ADDR_W:0] lim;
  logic [`SBP_ADDR_W:0] low;
  // extra bit keeps base plus barricade from wrapping past memory top
  assign low = reloc_form_i ? {1'b0, base_bank_i, {`SBP_BANK_SHIFT{1'b0}}}
                            : '0;
  assign lim = {1'b0, barr_bank_i, {`SBP_BANK_SHIFT{1'b0}}} + low; // R06 R08
  assign limit_o = lim[`SBP_ADDR_W-1:0];
  // protected below the base and from base plus barricade bank through the top of memory (base is zero unless relocation form)
  assign allowed_o = !prot_on_i || intr_mode_i ||
                     (({1'b0, phys_i} < lim) && ({1'b0, phys_i} >= low)); // R02 R07
endmodule : sbp_window
`default_nettype wire

// >>> sim/sbp_mem_model.sv
// character memory that answers the unit's memory port
`timescale 1ns/1ps
`default_nettype none
module sbp_mem_model (
  input  wire logic        ref_clk_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [18:0] addr_i,
  input  wire logic [5:0]  wdata_i,
  output logic      [5:0]  rdata_o
);
  logic [5:0] mem [0:524287];
  logic [5:0] idle_pat = 6'h2A;
  // unwritten locations read as a fixed filler character
  initial begin
    for (int i = 0; i < 524288; i++) mem[i] = 6'h15;
  end
  // index register area is plain storage here, no special case
  always @(posedge ref_clk_i) begin
    idle_pat <= ~idle_pat;
    if (req_i && we_i) mem[addr_i] <= wdata_i;
  end
  // idle port shows a toggling pattern so stale data never passes
  always @* begin
    if (!req_i) rdata_o = idle_pat;
    else rdata_o = mem[addr_i];
  end
endmodule : sbp_mem_model
`default_nettype wire

// >>> sim/sbp_barricade_tb.sv
// self-checking bench for the barricade unit
`timescale 1ns/1ps
`default_nettype none
`include "sbp_defines.svh"
module sbp_barricade_tb;
  import sbp_pkg::*;
  localparam int AW = `SBP_ADDR_W;
  logic          clk, nrst, ld, st, rf, im, po, cq, cw;
  logic [AW-1:0] aa, ba, nx, ca, ma, ib, sq, ar, br;
  logic [5:0]    cd, rd, md;
  logic          mq, mw, wk, bz, dn, tr, vi;
  logic [6:0]    bc, rb;
  int            error_cnt, n_compared;

  sbp_barricade #(.EXTENDED(1'b1)) dut (
    .ref_clk_i(clk), .nrst_i(nrst),
    .load_barricade_instruction_i(ld),
    .store_barricade_instruction_i(st),
    .reloc_form_i(rf), .a_addr_i(aa), .b_addr_i(ba),
    .next_instruction_addr_i(nx), .intr_mode_i(im), .prot_on_i(po),
    .cpu_req_i(cq), .cpu_we_i(cw), .cpu_addr_i(ca), .cpu_wdata_i(cd),
    .mem_rdata_i(rd), .mem_req_o(mq), .mem_we_o(mw),
    .mem_wm_keep_o(wk), .mem_addr_o(ma), .mem_wdata_o(md),
    .busy_o(bz), .done_o(dn), .privileged_trap_o(tr),
    .violation_o(vi), .barricade_bank_count_o(bc),
    .relocation_bank_base_o(rb), .index_base_o(ib),
    .sequence_reg_o(sq), .a_operand_addr_reg_o(ar),
    .b_operand_addr_reg_o(br)
  );

  sbp_mem_model mem_u (
    .ref_clk_i(clk), .req_i(mq), .we_i(mw), .addr_i(ma),
    .wdata_i(md), .rdata_o(rd)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [AW-1:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // instruction input is a level, dropped as soon as the answer shows
  task automatic instr(input logic is_ld, r, input logic [AW-1:0] a, b);
    int n;
    @(posedge clk);
    ld <= is_ld;
    st <= !is_ld;
    rf <= r;
    aa <= a;
    ba <= b;
    n = 0;
    // look only after an edge, so the last call's done pulse is not seen
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1 && tr !== 1'b1) chk("busy", 19'h1, 19'(bz));
    end while (n < 20 && dn !== 1'b1 && tr !== 1'b1);
    if (dn !== 1'b1 && tr !== 1'b1) begin
      error_cnt++;
      $display("Error instr_end expected 1 seen 0");
    end
    ld <= 1'b0;
    st <= 1'b0;
  endtask : instr

  task automatic cpu(input logic w, input logic [AW-1:0] a,
                     input logic [5:0] d, input logic [AW-1:0] ea,
                     input logic ereq, ewe, ev);
    @(posedge clk);
    cq <= 1'b1;
    cw <= w;
    ca <= a;
    cd <= d;
    #1;
    chk("mem_req", 19'(ereq), 19'(mq));
    chk("mem_we", 19'(ewe), 19'(mw));
    if (ereq) chk("mem_addr", ea, ma);
    @(posedge clk);
    cq <= 1'b0;
    #1;
    chk("violation", 19'(ev), 19'(vi));
  endtask : cpu

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end

  initial begin
    {nrst, ld, st, rf, po, cq, cw} = '0;
    im = 1'b1;
    {aa, ba, ca, cd} = '0;
    nx = 19'h01234;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("barricade", 19'h0, 19'(bc));
    chk("base", 19'h0, 19'(rb));
    mem_u.mem[19'h00100] = 6'h10;
    mem_u.mem[19'h000FF] = 6'h3F;
    instr(1'b1, 1'b0, 19'h00100, 19'h00400);
    chk("barricade", 19'h50, 19'(bc));
    chk("index_base", 19'h50000, ib);
    chk("a_reg", 19'h000FE, ar);
    chk("b_reg", 19'h00400, br);
    chk("seq_reg", 19'h01234, sq);
    $display("test load_basic done");
    mem_u.mem[19'h00500] = 6'h3F;
    mem_u.mem[19'h004FF] = 6'h3F;
    instr(1'b0, 1'b0, 19'h00500, 19'h00600);
    chk("store_a", 19'h10, 19'(mem_u.mem[19'h00500]));
    chk("store_a1", 19'h01, 19'(mem_u.mem[19'h004FF]));
    chk("wm_keep", 19'h1, 19'(wk));
    chk("b_reg", 19'h00600, br);
    $display("test store_basic done");
    mem_u.mem[19'h00200] = 6'h03;
    mem_u.mem[19'h001FF] = 6'h00;
    mem_u.mem[19'h00300] = 6'h02;
    mem_u.mem[19'h002FF] = 6'h3E;
    instr(1'b1, 1'b1, 19'h00200, 19'h00300);
    chk("barricade", 19'h03, 19'(bc));
    chk("base", 19'h02, 19'(rb));
    chk("index_base", 19'h05000, ib);
    chk("b_reg", 19'h002FE, br);
    $display("test load_reloc done");
    mem_u.mem[19'h00700] = 6'h3F;
    mem_u.mem[19'h006FF] = 6'h3F;
    mem_u.mem[19'h007FF] = 6'h3F;
    instr(1'b0, 1'b1, 19'h00800, 19'h00700);
    chk("store_b", 19'h02, 19'(mem_u.mem[19'h00700]));
    chk("store_b1", 19'h00, 19'(mem_u.mem[19'h006FF]));
    chk("store_a", 19'h03, 19'(mem_u.mem[19'h00800]));
    chk("store_a1", 19'h00, 19'(mem_u.mem[19'h007FF]));
    $display("test store_reloc done");
    @(posedge clk) im <= 1'b0;
    cpu(1'b0, 19'h00010, 6'h00, 19'h02010, 1'b1, 1'b0, 1'b0);
    @(posedge clk) po <= 1'b1;
    cpu(1'b1, 19'h00100, 6'h2D, 19'h02100, 1'b1, 1'b1, 1'b0);
    chk("inside", 19'h2D, 19'(mem_u.mem[19'h02100]));
    cpu(1'b1, 19'h02FFF, 6'h11, 19'h04FFF, 1'b1, 1'b1, 1'b0);
    cpu(1'b1, 19'h03100, 6'h2D, 19'h05100, 1'b0, 1'b0, 1'b1);
    chk("untouched", 19'h15, 19'(mem_u.mem[19'h05100]));
    cpu(1'b1, 19'h7F000, 6'h2D, 19'h01000, 1'b0, 1'b0, 1'b1);
    @(posedge clk) im <= 1'b1;
    cpu(1'b1, 19'h05000, 6'h22, 19'h05000, 1'b1, 1'b1, 1'b0);
    chk("index_area", 19'h22, 19'(mem_u.mem[19'h05000]));
    $display("test window done");
    @(posedge clk) im <= 1'b0;
    instr(1'b1, 1'b0, 19'h00100, 19'h00400);
    chk("trap", 19'h1, 19'(tr));
    chk("busy", 19'h0, 19'(bz));
    chk("barricade", 19'h03, 19'(bc));
    @(posedge clk) im <= 1'b1;
    $display("test privilege done");
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule : sbp_barricade_tb
`default_nettype wire
